// file: rtl/rsse_pkg.sv
// Constants for the reset state and sleep entry block.
// Assumes one 6 MHz system clock and a synchronous active-low reset.
// Functional notes
// - System clock from one fixed 6MHz oscillator
// - Sleep gates system clock, watchdog clock runs
// - Configuration option turns watchdog oscillator off
// - Only sleep instruction enters sleep
// - Sleep stops oscillator, halts program there
// - Sleep keeps memory and registers unchanged
// - Sleep clears watchdog counter if enabled
// - Sleep keeps port values and directions
// - Sleep sets sleep flag, clears timeout flag
// - Working register unknown at power-on, else kept
// - Status top bits follow cause table
// - Interrupt control clears except sleep timeout
// - Timer control resets 00-01 except sleep timeout
// - Port data/direction all ones except sleep timeout
// - System control 0100 0x00, bit2 undefined
// - Period timer clears except sleep timeout
// - Serial config clears; sleep timeout keeps low nibble
// - Serial bus control 0110 0000 except sleep timeout
// - Top status bits are timeout and sleep flags
// - Sleep timeout resets only counter and stack; code also clears system control bit2 and serial config high nibble
package rsse_pkg;
	typedef enum logic [2:0] {
		RSSE_CAUSE_NONE,
		RSSE_CAUSE_POWER_ON,
		RSSE_CAUSE_WDT_RUN,
		RSSE_CAUSE_PIN_RUN,
		RSSE_CAUSE_PIN_SLEEP,
		RSSE_CAUSE_WDT_SLEEP
	} rsse_cause_t;

	localparam int          RSSE_PORT_COUNT    = 5;
	localparam logic [7:0]  RSSE_PCL_RESET     = 8'h00;
	localparam logic [6:0]  RSSE_INTERRUPT_CONTROL_RESET    = 7'h00;
	localparam logic [6:0]  RSSE_INTERRUPT_CONTROL_MASK     = 7'h7F;
	localparam logic [4:0]  RSSE_TIMER_CONTROL_RESET    = 5'h01;
	localparam logic [4:0]  RSSE_TIMER_CONTROL_MASK     = 5'h1B;
	localparam logic [7:0]  RSSE_PORT_RESET    = 8'hFF;
	localparam logic [2:0]  RSSE_WATCHDOG_SELECT_RESET    = 3'h7;
	localparam logic [7:0]  RSSE_SYSTEM_CONTROL_RESET    = 8'h40;
	localparam int          RSSE_SYSTEM_CONTROL_UNDEF    = 2;
	localparam logic [7:0]  RSSE_PTR_RESET     = 8'h00;
	localparam logic [7:0]  RSSE_SERIAL_PORT_CONFIG_RESET    = 8'h00;
	localparam logic [7:0]  RSSE_SERIAL_PORT_CONFIG_KEEP     = 8'h0F;
	localparam logic [7:0]  RSSE_SERIAL_BUS_CONTROL_RESET    = 8'h60;
	localparam int          RSSE_STAT_TO_BIT   = 5;
	localparam int          RSSE_STAT_PDF_BIT  = 4;
	localparam int          RSSE_SYNC_STAGES   = 2;
	localparam int          RSSE_WDT_WIDTH     = 13;
	localparam int          RSSE_SYS_HZ        = 6000000;
endpackage

// file: rtl/rsse_sync.sv
// Two-flop synchroniser for pin levels.
// Assumes input arrives asynchronously to clk_i.
`timescale 1ns/1ps
module rsse_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// Data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// file: rtl/rsse_wdt_counter.sv
// Watchdog counter clocked by enable pulses from the watchdog oscillator.
// Assumes tick_i is already synchronised and one cycle long.
`timescale 1ns/1ps
module rsse_wdt_counter #(
	parameter int WIDTH = rsse_pkg::RSSE_WDT_WIDTH
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// Control
	input  wire logic enable_i,
	input  wire logic clear_i,
	input  wire logic tick_i,
	// Status
	output logic      overflow_o
);
	logic [WIDTH-1:0] count_q;

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i || clear_i || !enable_i)
			count_q <= '0;
		else if (tick_i)
			count_q <= count_q + 1'b1;
	end

	// Pulse once on wrap, never while held clear
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i || clear_i || !enable_i)
			overflow_o <= 1'b0;
		else
			overflow_o <= tick_i && (&count_q);
	end
endmodule

// file: rtl/rsse_top.sv
// Reset cause classifier, special register reset loader and sleep entry.
// Assumes the core supplies write strobes and a one-cycle sleep instruction pulse.
`timescale 1ns/1ps
module rsse_top #(
	parameter int PORTS = rsse_pkg::RSSE_PORT_COUNT
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	// Reset sources
	input  wire logic               power_on_i,
	input  wire logic               external_clear_pin_n_i,
	// Configuration option and watchdog oscillator tick
	input  wire logic               wdt_osc_enable_i,
	input  wire logic               wdt_osc_tick_i,
	// Core events
	input  wire logic               sleep_instr_i,
	input  wire logic               wake_i,
	input  wire logic               clr_wdt_i,
	// Core register writes
	input  wire logic               write_i,
	input  wire logic [3:0]         write_sel_i,
	input  wire logic [7:0]         write_data_i,
	input  wire logic [2:0]         write_port_i,
	// Register images
	output logic      [7:0]         program_counter_low_o,
	output logic      [7:0]         working_register_o,
	output logic      [7:0]         status_o,
	output logic      [7:0]         interrupt_control_o,
	output logic      [7:0]         timer_control_o,
	output logic      [PORTS*8-1:0] port_data_o,
	output logic      [PORTS*8-1:0] port_direction_o,
	output logic      [7:0]         watchdog_select_o,
	output logic      [7:0]         system_control_o,
	output logic      [7:0]         period_timer_count_o,
	output logic      [7:0]         serial_port_config_o,
	output logic      [7:0]         serial_bus_control_o,
	// Clock and state
	output logic                    sys_clk_run_o,
	output logic                    sleeping_o,
	output logic                    wdt_running_o,
	output logic                    reset_pulse_o,
	output logic      [2:0]         reset_cause_o
);
	// Write select codes for the core port
	localparam logic [3:0] SEL_ACC  = 4'h0;
	localparam logic [3:0] SEL_STAT = 4'h1;
	localparam logic [3:0] SEL_INTERRUPT_CONTROL = 4'h2;
	localparam logic [3:0] SEL_TIMER_CONTROL = 4'h3;
	localparam logic [3:0] SEL_PD   = 4'h4;
	localparam logic [3:0] SEL_PDIR = 4'h5;
	localparam logic [3:0] SEL_WATCHDOG_SELECT = 4'h6;
	localparam logic [3:0] SEL_SYSTEM_CONTROL = 4'h7;
	localparam logic [3:0] SEL_PTR  = 4'h8;
	localparam logic [3:0] SEL_SERIAL_PORT_CONFIG = 4'h9;
	localparam logic [3:0] SEL_SERIAL_BUS_CONTROL = 4'hA;
	localparam logic [3:0] SEL_PCL  = 4'hB;

	logic              pin_s;
	logic              pin_q;
	logic              wdt_tick_s;
	logic              wdt_tick_q;
	logic              wdt_overflow;
	logic              sleep_q;
	logic              wdt_clear;
	logic              pin_fall;
	rsse_pkg::rsse_cause_t cause_d;
	rsse_pkg::rsse_cause_t cause_q;
	logic              full_reset;
	logic              wdt_sleep;

	function automatic logic wr_hit(input logic [3:0] sel);
		wr_hit = write_i && (write_sel_i == sel) && !sleep_q;
	endfunction

	// Pin inverted so its idle level matches the synchroniser reset value
	rsse_sync #(.WIDTH(2)) u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.async_i   ({!external_clear_pin_n_i, wdt_osc_tick_i}),
		.sync_o    ({pin_s, wdt_tick_s})
	);

	// Edge detect on the synchronised copies only
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			pin_q      <= 1'b0;
			wdt_tick_q <= 1'b0;
		end
		else
		begin
			pin_q      <= pin_s;
			wdt_tick_q <= wdt_tick_s;
		end
	end

	assign pin_fall  = pin_s && !pin_q;
	// Watchdog cleared by sleep entry, its instruction, or a pin reset
	assign wdt_clear = (sleep_instr_i && !sleep_q) || clr_wdt_i || pin_fall;

	rsse_wdt_counter u_wdt (
		.clk_i      (clk_i),
		.reset_n_i  (reset_n_i),
		.enable_i   (wdt_osc_enable_i && (watchdog_select_o[2:0] != 3'h0)),
		.clear_i    (wdt_clear),
		.tick_i     (wdt_tick_s && !wdt_tick_q),
		.overflow_o (wdt_overflow)
	);

	// Cause priority: power-on over pin over watchdog
	always_comb
	begin
		cause_d = rsse_pkg::RSSE_CAUSE_NONE;
		if (power_on_i)
			cause_d = rsse_pkg::RSSE_CAUSE_POWER_ON;
		else if (pin_fall)
			cause_d = sleep_q ? rsse_pkg::RSSE_CAUSE_PIN_SLEEP
			                  : rsse_pkg::RSSE_CAUSE_PIN_RUN;
		else if (wdt_overflow && (!sleep_q || period_timer_count_o == 8'h00))
			cause_d = sleep_q ? rsse_pkg::RSSE_CAUSE_WDT_SLEEP
			                  : rsse_pkg::RSSE_CAUSE_WDT_RUN;
	end

	assign full_reset = !reset_n_i || (cause_d != rsse_pkg::RSSE_CAUSE_NONE
	                    && cause_d != rsse_pkg::RSSE_CAUSE_WDT_SLEEP);
	assign wdt_sleep  = reset_n_i && (cause_d == rsse_pkg::RSSE_CAUSE_WDT_SLEEP);

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			cause_q       <= rsse_pkg::RSSE_CAUSE_POWER_ON;
			reset_pulse_o <= 1'b1;
		end
		else
		begin
			if (cause_d != rsse_pkg::RSSE_CAUSE_NONE)
				cause_q <= cause_d;
			reset_pulse_o <= (cause_d != rsse_pkg::RSSE_CAUSE_NONE);
		end
	end

	assign reset_cause_o = cause_q;

	// Sleep only via the instruction; any reset or wake ends it
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i || cause_d != rsse_pkg::RSSE_CAUSE_NONE || wake_i)
			sleep_q <= 1'b0;
		else if (sleep_instr_i)
			sleep_q <= 1'b1;
	end

	// Gating the 6MHz core clock; watchdog path stays live
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			sleeping_o    <= 1'b0;
			sys_clk_run_o <= 1'b1;
			wdt_running_o <= 1'b0;
		end
		else
		begin
			sleeping_o    <= sleep_q;
			sys_clk_run_o <= !sleep_q;
			wdt_running_o <= wdt_osc_enable_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (full_reset || wdt_sleep)
			program_counter_low_o <= rsse_pkg::RSSE_PCL_RESET;
		else if (wr_hit(SEL_PCL))
			program_counter_low_o <= write_data_i;
	end

	// Unknown at power-on: loaded zero, kept on all other causes
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i || cause_d == rsse_pkg::RSSE_CAUSE_POWER_ON)
			working_register_o <= 8'h00;
		else if (wr_hit(SEL_ACC))
			working_register_o <= write_data_i;
	end

	// Flag events win over software writes to status
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			status_o <= 8'h00;
		else
		begin
			unique case (cause_d)
				rsse_pkg::RSSE_CAUSE_POWER_ON:
					status_o <= 8'h00;
				rsse_pkg::RSSE_CAUSE_WDT_RUN:
					status_o[rsse_pkg::RSSE_STAT_TO_BIT] <= 1'b1;
				rsse_pkg::RSSE_CAUSE_PIN_SLEEP:
				begin
					status_o[rsse_pkg::RSSE_STAT_TO_BIT]  <= 1'b0;
					status_o[rsse_pkg::RSSE_STAT_PDF_BIT] <= 1'b1;
				end
				rsse_pkg::RSSE_CAUSE_WDT_SLEEP:
				begin
					status_o[rsse_pkg::RSSE_STAT_TO_BIT]  <= 1'b1;
					status_o[rsse_pkg::RSSE_STAT_PDF_BIT] <= 1'b1;
				end
				rsse_pkg::RSSE_CAUSE_PIN_RUN:
					status_o <= status_o;
				default:
				begin
					if (sleep_instr_i && !sleep_q)
					begin
						status_o[rsse_pkg::RSSE_STAT_PDF_BIT] <= 1'b1;
						status_o[rsse_pkg::RSSE_STAT_TO_BIT]  <= 1'b0;
					end
					else if (clr_wdt_i)
					begin
						status_o[rsse_pkg::RSSE_STAT_PDF_BIT] <= 1'b0;
						status_o[rsse_pkg::RSSE_STAT_TO_BIT]  <= 1'b0;
					end
					else if (wr_hit(SEL_STAT))
						status_o[3:0] <= write_data_i[3:0];
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (full_reset)
			interrupt_control_o <= {1'b0, rsse_pkg::RSSE_INTERRUPT_CONTROL_RESET};
		else if (wr_hit(SEL_INTERRUPT_CONTROL))
			interrupt_control_o <= {1'b0, write_data_i[6:0] & rsse_pkg::RSSE_INTERRUPT_CONTROL_MASK};
	end

	always_ff @(posedge clk_i)
	begin
		if (full_reset)
			timer_control_o <= {3'h0, rsse_pkg::RSSE_TIMER_CONTROL_RESET};
		else if (wr_hit(SEL_TIMER_CONTROL))
			timer_control_o <= {3'h0, write_data_i[4:0] & rsse_pkg::RSSE_TIMER_CONTROL_MASK};
	end

	genvar gi;
	generate
		for (gi = 0; gi < PORTS; gi++)
		begin : g_port
			always_ff @(posedge clk_i)
			begin
				if (full_reset)
				begin
					port_data_o[gi*8 +: 8]      <= rsse_pkg::RSSE_PORT_RESET;
					port_direction_o[gi*8 +: 8] <= rsse_pkg::RSSE_PORT_RESET;
				end
				else if (write_port_i == 3'(gi))
				begin
					// Sleep blocks writes, so pins hold their state
					if (wr_hit(SEL_PD))
						port_data_o[gi*8 +: 8] <= write_data_i;
					if (wr_hit(SEL_PDIR))
						port_direction_o[gi*8 +: 8] <= write_data_i;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (full_reset)
			watchdog_select_o <= {5'h00, rsse_pkg::RSSE_WATCHDOG_SELECT_RESET};
		else if (wr_hit(SEL_WATCHDOG_SELECT))
			watchdog_select_o <= {5'h00, write_data_i[2:0]};
	end

	// Undefined bit driven zero on both paths
	always_ff @(posedge clk_i)
	begin
		if (full_reset)
			system_control_o <= rsse_pkg::RSSE_SYSTEM_CONTROL_RESET;
		else if (wdt_sleep)
			system_control_o[rsse_pkg::RSSE_SYSTEM_CONTROL_UNDEF] <= 1'b0;
		else if (wr_hit(SEL_SYSTEM_CONTROL))
			system_control_o <= write_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (full_reset)
			period_timer_count_o <= rsse_pkg::RSSE_PTR_RESET;
		else if (wr_hit(SEL_PTR))
			period_timer_count_o <= write_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (full_reset)
			serial_port_config_o <= rsse_pkg::RSSE_SERIAL_PORT_CONFIG_RESET;
		else if (wdt_sleep)
			serial_port_config_o <= serial_port_config_o & rsse_pkg::RSSE_SERIAL_PORT_CONFIG_KEEP;
		else if (wr_hit(SEL_SERIAL_PORT_CONFIG))
			serial_port_config_o <= write_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (full_reset)
			serial_bus_control_o <= rsse_pkg::RSSE_SERIAL_BUS_CONTROL_RESET;
		else if (wr_hit(SEL_SERIAL_BUS_CONTROL))
			serial_bus_control_o <= write_data_i;
	end
endmodule

// file: verif/rsse_properties.sv
// Checker for reset load patterns and sleep entry of rsse_top.
// Assumes it is bound onto rsse_top and sees only its ports.
`timescale 1ns/1ps
module rsse_checker #(
	parameter int PORTS = 5
) (
	// Clock and reset
	input wire logic               clk_i,
	input wire logic               reset_n_i,
	// Core events
	input wire logic               sleep_instr_i,
	// Register images
	input wire logic [7:0]         program_counter_low_o,
	input wire logic [7:0]         working_register_o,
	input wire logic [7:0]         status_o,
	input wire logic [7:0]         interrupt_control_o,
	input wire logic [7:0]         timer_control_o,
	input wire logic [PORTS*8-1:0] port_data_o,
	input wire logic [PORTS*8-1:0] port_direction_o,
	input wire logic [7:0]         watchdog_select_o,
	input wire logic [7:0]         system_control_o,
	input wire logic [7:0]         serial_bus_control_o,
	// Clock and state
	input wire logic               sys_clk_run_o,
	input wire logic               sleeping_o,
	input wire logic               reset_pulse_o,
	input wire logic [2:0]         reset_cause_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_sleep_flags: assert property (
		sleep_instr_i && !sleeping_o |=> status_o[5:4] == 2'h1)
		else $error("sleep flags wrong");
	a_sleep_stops_clk: assert property (
		sleep_instr_i && !sleeping_o |-> ##2 (sleeping_o && !sys_clk_run_o))
		else $error("clock not stopped in sleep");
	a_sleep_only_instr: assert property (
		$rose(sleeping_o) |-> $past(sleep_instr_i, 2))
		else $error("sleep without instruction");
	// Reset pulse excluded: a pin reset in sleep reloads ports
	a_sleep_keeps_ports: assert property (
		sleeping_o && $past(sleeping_o) && !reset_pulse_o
		|-> $stable(port_data_o) && $stable(port_direction_o) && $stable(working_register_o))
		else $error("state changed in sleep");
	a_unimp_bits_zero: assert property (
		!interrupt_control_o[7] && (timer_control_o & 8'hE4) == 8'h00
		&& watchdog_select_o[7:3] == 5'h00)
		else $error("unimplemented bit set");
	a_reset_pc_zero: assert property (
		reset_pulse_o |-> program_counter_low_o == 8'h00)
		else $error("program counter not cleared");
	a_pin_sleep_status: assert property (
		reset_pulse_o && reset_cause_o == 3'h4 |-> status_o[5:4] == 2'h1)
		else $error("pin wake status wrong");
	a_reset_loads: assert property (
		reset_pulse_o && reset_cause_o != 3'h5
		|-> &port_data_o && &port_direction_o && system_control_o == 8'h40
		&& serial_bus_control_o == 8'h60)
		else $error("reset load pattern wrong");
	a_wdt_sleep_status: assert property (
		reset_pulse_o && reset_cause_o == 3'h5
		|-> status_o[5:4] == 2'h3 && program_counter_low_o == 8'h00)
		else $error("watchdog wake status wrong");

	c_pin_sleep: cover property (reset_pulse_o && reset_cause_o == 3'h4);
	c_pin_run: cover property (reset_pulse_o && reset_cause_o == 3'h3);
	c_sleep: cover property ($rose(sleeping_o));
	c_wdt_sleep: cover property (reset_pulse_o && reset_cause_o == 3'h5);
endmodule

bind rsse_top rsse_checker #(.PORTS(PORTS)) chk_u (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.sleep_instr_i(sleep_instr_i),
	.program_counter_low_o(program_counter_low_o),
	.working_register_o(working_register_o),
	.status_o(status_o),
	.interrupt_control_o(interrupt_control_o),
	.timer_control_o(timer_control_o),
	.port_data_o(port_data_o),
	.port_direction_o(port_direction_o),
	.watchdog_select_o(watchdog_select_o),
	.system_control_o(system_control_o),
	.serial_bus_control_o(serial_bus_control_o),
	.sys_clk_run_o(sys_clk_run_o),
	.sleeping_o(sleeping_o),
	.reset_pulse_o(reset_pulse_o),
	.reset_cause_o(reset_cause_o)
);

// file: verif/tb.sv
// Self-checking bench for reset loads and sleep entry.
// Assumes rsse_top with two ports; watchdog ticks toggle only in watchdog tests.
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        pin_n = 1'b1;
	logic        wdt_en = 1'b1;
	logic        sleep_i = 1'b0;
	logic        po = 1'b0;
	logic        tick = 1'b0;
	logic        wr_i = 1'b0;
	logic [3:0]  wr_sel = 4'h0;
	logic [7:0]  wr_dat = 8'h00;
	logic [7:0]  program_counter_low, acc, st, interrupt_control, timer_control, watchdog_select, system_control, ptr, serial_port_config, serial_bus_control;
	logic [15:0] pd, pdir;
	logic        clk_run, slp, wdt_run, rpulse;
	logic [2:0]  cause;
	int          n_errors = 0;
	int          compares = 0;

	always #2 clk_i = ~clk_i;

	rsse_top #(.PORTS(2)) dut_u (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .power_on_i(po),
		.external_clear_pin_n_i(pin_n), .wdt_osc_enable_i(wdt_en),
		.wdt_osc_tick_i(tick), .sleep_instr_i(sleep_i), .wake_i(1'b0),
		.clr_wdt_i(1'b0), .write_i(wr_i), .write_sel_i(wr_sel),
		.write_data_i(wr_dat), .write_port_i(3'h0),
		.program_counter_low_o(program_counter_low), .working_register_o(acc), .status_o(st),
		.interrupt_control_o(interrupt_control), .timer_control_o(timer_control), .port_data_o(pd),
		.port_direction_o(pdir), .watchdog_select_o(watchdog_select),
		.system_control_o(system_control), .period_timer_count_o(ptr),
		.serial_port_config_o(serial_port_config), .serial_bus_control_o(serial_bus_control),
		.sys_clk_run_o(clk_run), .sleeping_o(slp), .wdt_running_o(wdt_run),
		.reset_pulse_o(rpulse), .reset_cause_o(cause)
	);

	task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] sel, input logic [7:0] dat);
		@(posedge clk_i);
		wr_i <= 1'b1;
		wr_sel <= sel;
		wr_dat <= dat;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask

	// Pin low until the load pulse, checked inside that cycle
	task automatic pin_rst(input logic [2:0] exp_cause);
		@(posedge clk_i);
		pin_n <= 1'b0;
		for (int i = 0; i < 10 && rpulse !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		cmp("cause", exp_cause, cause);
		cmp("pcl", 8'h00, program_counter_low);
	endtask

	task automatic pin_release();
		@(posedge clk_i);
		pin_n <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic t_reset();
		cmp("status", 8'h00, st);
		cmp("interrupt_control", 8'h00, interrupt_control);
		cmp("timer_control", 8'h01, timer_control);
		cmp("pd", 16'hFFFF, pd);
		cmp("pdir", 16'hFFFF, pdir);
		cmp("watchdog_select", 8'h07, watchdog_select);
		cmp("system_control", 8'h40, system_control);
		cmp("ptr", 8'h00, ptr);
		cmp("serial_port_config", 8'h00, serial_port_config);
		cmp("serial_bus_control", 8'h60, serial_bus_control);
		cmp("wdt run", 1'b1, wdt_run);
		$display("test reset done");
	endtask

	// Toggle the watchdog oscillator until a reset pulse appears
	task automatic tick_until_reset();
		for (int i = 0; i < 20000 && rpulse !== 1'b1; i++)
		begin
			@(posedge clk_i);
			tick <= !tick;
			#1;
		end
		@(posedge clk_i);
		tick <= 1'b0;
		#1;
	endtask

	task automatic t_power();
		wr(4'h0, 8'h5A);
		wr(4'h1, 8'h03);
		@(posedge clk_i);
		po <= 1'b1;
		@(posedge clk_i);
		po <= 1'b0;
		#1;
		cmp("pulse", 1'b1, rpulse);
		cmp("cause", 3'h1, cause);
		cmp("acc", 8'h00, acc);
		cmp("status", 8'h00, st);
		@(posedge clk_i);
		wdt_en <= 1'b0;
		@(posedge clk_i);
		#1;
		cmp("wdt run", 1'b0, wdt_run);
		@(posedge clk_i);
		wdt_en <= 1'b1;
		$display("test power on done");
	endtask

	task automatic t_wdt_run();
		wr(4'h4, 8'h00);
		wr(4'hB, 8'h55);
		tick_until_reset();
		cmp("cause", 3'h2, cause);
		cmp("status", 8'h33, st);
		cmp("pcl", 8'h00, program_counter_low);
		cmp("pd", 16'hFFFF, pd);
		$display("test watchdog run done");
	endtask

	task automatic t_wdt_sleep();
		wr(4'h2, 8'hFF);
		wr(4'h9, 8'hAB);
		wr(4'h7, 8'hFF);
		wr(4'h4, 8'h00);
		wr(4'hB, 8'h55);
		@(posedge clk_i);
		sleep_i <= 1'b1;
		@(posedge clk_i);
		sleep_i <= 1'b0;
		tick_until_reset();
		cmp("cause", 3'h5, cause);
		cmp("status", 8'h33, st);
		cmp("pcl", 8'h00, program_counter_low);
		cmp("interrupt_control", 8'h7F, interrupt_control);
		cmp("serial_port_config", 8'h0B, serial_port_config);
		cmp("system_control", 8'hFB, system_control);
		cmp("pd", 16'hFF00, pd);
		$display("test watchdog sleep done");
	endtask

	task automatic t_sleep();
		wr(4'h0, 8'h5A);
		wr(4'h1, 8'h03);
		wr(4'h2, 8'hFF);
		wr(4'h3, 8'hFF);
		wr(4'h6, 8'hFF);
		wr(4'h4, 8'h00);
		cmp("interrupt_control", 8'h7F, interrupt_control);
		cmp("timer_control", 8'h1B, timer_control);
		cmp("watchdog_select", 8'h07, watchdog_select);
		@(posedge clk_i);
		sleep_i <= 1'b1;
		@(posedge clk_i);
		sleep_i <= 1'b0;
		@(posedge clk_i);
		#1;
		cmp("status", 8'h13, st);
		cmp("sleeping", 1'b1, slp);
		cmp("clk run", 1'b0, clk_run);
		// Writes while asleep must not land
		wr(4'h0, 8'h00);
		cmp("acc", 8'h5A, acc);
		cmp("pd", 16'hFF00, pd);
		$display("test sleep done");
	endtask

	task automatic t_pin_sleep();
		pin_rst(3'h4);
		cmp("status", 8'h13, st);
		cmp("acc", 8'h5A, acc);
		cmp("interrupt_control", 8'h00, interrupt_control);
		cmp("timer_control", 8'h01, timer_control);
		cmp("pd", 16'hFFFF, pd);
		pin_release();
		$display("test pin sleep done");
	endtask

	task automatic t_pin_run();
		wr(4'hB, 8'h44);
		wr(4'h8, 8'h33);
		wr(4'h9, 8'hAB);
		wr(4'h7, 8'h00);
		wr(4'hA, 8'h00);
		cmp("ptr", 8'h33, ptr);
		pin_rst(3'h3);
		cmp("status", 8'h13, st);
		cmp("ptr", 8'h00, ptr);
		cmp("serial_port_config", 8'h00, serial_port_config);
		cmp("system_control", 8'h40, system_control);
		cmp("serial_bus_control", 8'h60, serial_bus_control);
		pin_release();
		$display("test pin run done");
	endtask

	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		#1;
		t_reset();
		t_power();
		t_sleep();
		t_pin_sleep();
		t_pin_run();
		t_wdt_run();
		t_wdt_sleep();
		end_sim();
	end

	// Tests need about 33000 cycles, mostly two watchdog wraps
	initial
	begin
		repeat (40000) @(posedge clk_i);
		n_errors++;
		end_sim();
	end
endmodule
